/* core/pwc_channel.v */
// ==========================================
`timescale 1ns/10ps
module pwc_channel #(
  parameter CW = 8
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // waveform pin
  output reg pwmOut
);
`include "pwc_map.vh"
  // ==========================================
  // registers
  reg [`PWC_CTRL_WIDTH-1:0] ctrl_r;
  reg [CW-1:0] prescale_r;
  reg [CW-1:0] count_r;
  reg [CW-1:0] count_nxt;
  reg countDown_r;
  reg countDown_nxt;
  reg flop_r;
  reg flop_nxt;
  reg enPrev_r;
  reg [31:0] rdata_nxt;
  reg known;
  wire enable;
  wire polarity;
  wire center;
  wire tick;
  wire gateOn;
  wire [CW-1:0] perBuf;
  wire [CW-1:0] perAct;
  wire [CW-1:0] dutyBuf;
  wire [CW-1:0] dutyAct;
  wire setup;
  wire wrCtrl;
  wire wrCounter;
  wire wrPeriod;
  wire wrDuty;
  wire wrPrescale;
  wire periodEnd;
  wire update;
  wire [CW-1:0] one;
  assign enable = ctrl_r[`PWC_CTRL_ENABLE];
  assign polarity = ctrl_r[`PWC_CTRL_POLARITY];
  assign center = ctrl_r[`PWC_CTRL_CENTER];
  assign one = {{(CW-1){1'b0}}, 1'b1};

  // ==========================================
  // bus decode
  // the access is answered in the cycle after its first access cycle, so pready pulses once per transfer
  assign setup = psel & penable & ~pready;
  assign wrCtrl = setup & pwrite & (paddr == `PWC_ADDR_CTRL);
  assign wrCounter = setup & pwrite & (paddr == `PWC_ADDR_COUNTER);
  assign wrPeriod = setup & pwrite & (paddr == `PWC_ADDR_PERIOD);
  assign wrDuty = setup & pwrite & (paddr == `PWC_ADDR_DUTY);
  assign wrPrescale = setup & pwrite & (paddr == `PWC_ADDR_PRESCALE);

  always @* begin
    known = 1'b1;
    rdata_nxt = `PWC_ZERO_WORD;
    case (paddr)
      `PWC_ADDR_CTRL: begin
        rdata_nxt[`PWC_CTRL_WIDTH-1:0] = ctrl_r;
      end
      `PWC_ADDR_COUNTER: begin
        rdata_nxt[CW-1:0] = count_r;
      end
      `PWC_ADDR_PERIOD: begin
        rdata_nxt[CW-1:0] = perBuf;
      end
      `PWC_ADDR_DUTY: begin
        rdata_nxt[CW-1:0] = dutyBuf;
      end
      `PWC_ADDR_PRESCALE: begin
        rdata_nxt[CW-1:0] = prescale_r;
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `PWC_ZERO_WORD;
      ctrl_r <= `PWC_RST_CTRL;
      prescale_r <= `PWC_RST_PRESCALE;
    end else begin
      pready <= setup;
      pslverr <= setup & ~known;
      if (setup && !pwrite) begin
        prdata <= rdata_nxt;
      end
      if (wrCtrl) begin
        ctrl_r <= pwdata[`PWC_CTRL_WIDTH-1:0];
      end
      if (wrPrescale) begin
        prescale_r <= pwdata[CW-1:0];
      end
    end
  end

  // ==========================================
  // channel clock and double buffers
  // the gate waits for a prescaler tick, so the first cycle after enable starts late but is never short
  pwc_clock_gate #(
    .WIDTH(CW)
  ) gate (
    .clk(clk),
    .rst(rst),
    .divide(prescale_r),
    .enable(enable),
    .tick(tick),
    .gateOn(gateOn)
  );

  // update on period end, counter write or the falling edge of enable
  assign update = periodEnd | wrCounter | (enPrev_r & ~enable);

  pwc_dbuf #(
    .WIDTH(CW)
  ) perReg (
    .clk(clk),
    .rst(rst),
    .wrEn(wrPeriod),
    .wrData(pwdata[CW-1:0]),
    .running(enable),
    .update(update),
    .bufVal(perBuf),
    .activeVal(perAct)
  );

  pwc_dbuf #(
    .WIDTH(CW)
  ) dutyReg (
    .clk(clk),
    .rst(rst),
    .wrEn(wrDuty),
    .wrData(pwdata[CW-1:0]),
    .running(enable),
    .update(update),
    .bufVal(dutyBuf),
    .activeVal(dutyAct)
  );

  // ==========================================
  // counter and output flip-flop
  // left: count 0..per-1 then wrap; centre: up to per, down to 0
  assign periodEnd = tick & (center ? (countDown_r && count_r == one)
                                    : (count_r + one >= perAct));

  always @* begin
    count_nxt = count_r;
    countDown_nxt = countDown_r;
    flop_nxt = flop_r;
    if (wrCounter) begin
      count_nxt = `PWC_RST_BYTE;
      countDown_nxt = 1'b0;
      flop_nxt = 1'b0;
    end else if (tick) begin
      if (!center) begin
        if (periodEnd) begin
          count_nxt = `PWC_RST_BYTE;
          flop_nxt = 1'b0;
        end else begin
          count_nxt = count_r + one;
          if (count_r + one == dutyAct) begin
            flop_nxt = 1'b1;
          end
        end
      end else begin
        if (!countDown_r) begin
          count_nxt = count_r + one;
          if (count_r + one >= perAct) begin
            countDown_nxt = 1'b1;
          end
        end else begin
          count_nxt = count_r - one;
          if (count_r == one) begin
            countDown_nxt = 1'b0;
          end
        end
        flop_nxt = (count_nxt >= dutyAct);
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      count_r <= `PWC_RST_BYTE;
      countDown_r <= 1'b0;
      flop_r <= 1'b0;
      enPrev_r <= 1'b0;
      pwmOut <= 1'b0;
    end else begin
      count_r <= count_nxt;
      countDown_r <= countDown_nxt;
      flop_r <= flop_nxt;
      enPrev_r <= enable;
      // duty counts the high time with polarity set, the low time otherwise
      pwmOut <= polarity ? ~flop_nxt : flop_nxt;
    end
  end
endmodule

/* core/pwc_clock_gate.v */
`timescale 1ns/10ps
// edge-synchronised enable: a tick train from a prescaler, gated on only at tick boundaries, gated off at once when enable drops
module pwc_clock_gate #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire [WIDTH-1:0] divide,
  input wire enable,
  // gated tick
  output reg tick,
  output reg gateOn
);
`include "pwc_map.vh"
  reg [WIDTH-1:0] divCount_r;
  wire rawTick;
  assign rawTick = (divCount_r == divide);
  always @(posedge clk) begin
    if (rst) begin
      divCount_r <= {WIDTH{1'b0}};
      gateOn <= 1'b0;
      tick <= 1'b0;
    end else begin
      if (rawTick) begin
        divCount_r <= {WIDTH{1'b0}};
      end else begin
        divCount_r <= divCount_r + {{(WIDTH-1){1'b0}}, 1'b1};
      end
      // gateOn only follows enable on a tick edge, so no partial ticks reach the counter
      if (rawTick) begin
        gateOn <= enable;
      end
      tick <= rawTick & gateOn & enable;
    end
  end
endmodule

/* core/pwc_dbuf.v */
`timescale 1ns/10ps
// double-buffered value: buffer written by software, latch loaded on an update event
module pwc_dbuf #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // write side
  input wire wrEn,
  input wire [WIDTH-1:0] wrData,
  input wire running,
  input wire update,
  // values
  output reg [WIDTH-1:0] bufVal,
  output reg [WIDTH-1:0] activeVal
);
  always @(posedge clk) begin
    if (rst) begin
      bufVal <= {WIDTH{1'b0}};
      activeVal <= {WIDTH{1'b0}};
    end else begin
      if (wrEn) begin
        bufVal <= wrData;
      end
      if (wrEn && !running) begin
        activeVal <= wrData;
      end else if (update) begin
        activeVal <= bufVal;
      end
    end
  end
endmodule

/* shared/pwc_map.vh */
`ifndef PWC_MAP_VH
`define PWC_MAP_VH
// ==========================================
// register byte addresses
`define PWC_ADDR_CTRL 12'h000
`define PWC_ADDR_COUNTER 12'h004
`define PWC_ADDR_PERIOD 12'h008
`define PWC_ADDR_DUTY 12'h00c
`define PWC_ADDR_PRESCALE 12'h010
// ==========================================
// control register fields
`define PWC_CTRL_ENABLE 0
`define PWC_CTRL_POLARITY 1
`define PWC_CTRL_CENTER 2
`define PWC_CTRL_WIDTH 3
// ==========================================
// reset values
`define PWC_RST_BYTE 8'h00
`define PWC_RST_CTRL 3'h0
`define PWC_RST_PRESCALE 8'h00
`define PWC_ONE_BYTE 8'h01
`define PWC_ZERO_WORD 32'h00000000
`endif

/* testbench/pwc_channel_checker.sv */
`timescale 1ns/10ps
module pwc_channel_checker #(
  parameter CW = 8
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // pin
  input wire pwmOut
);
  // ====
  // helpers
  wire acc = psel && penable && !pready;
  wire mapped = paddr <= 12'h010 && paddr[1:0] == 2'h0;
  reg [7:0] perW_r;
  always @(posedge clk) begin
    if (rst) perW_r <= 8'h00;
    else if (acc && pwrite && paddr == 12'h008) perW_r <= pwdata[7:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ====
  // properties
  AST_ANSWER: assert property (acc |=> pready) else $error("no answer");
  AST_PULSE: assert property (pready |=> !pready) else $error("long pready");
  AST_IDLE: assert property (!(psel && penable) |=> !pready) else $error("stray pready");
  AST_ERRPAIR: assert property (pslverr |-> pready) else $error("lone pslverr");
  // writes leave prdata alone, so only an unmapped read must return zero
  AST_UNMAP: assert property (acc && !mapped |=> pslverr) else $error("unmapped taken");
  AST_UNMAPRD: assert property (acc && !mapped && !pwrite |=> prdata == 32'h0)
    else $error("unmapped read data");
  AST_MAPOK: assert property (acc && mapped |=> !pslverr) else $error("mapped refused");
  AST_HOLD: assert property (!$past(acc && !pwrite) |-> $stable(prdata))
    else $error("prdata moved");
  AST_BYTE: assert property (acc && !pwrite |=> prdata[31:8] == 24'h0)
    else $error("upper bits set");
  AST_PERRD: assert property (acc && !pwrite && paddr == 12'h008 |=> prdata[7:0] == perW_r)
    else $error("period readback");
endmodule

bind pwc_channel pwc_channel_checker #(.CW(CW)) pwc_channel_checker_inst (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwmOut(pwmOut));

/* testbench/pwc_channel_tb_top.sv */
`timescale 1ns/10ps
`include "pwc_map.vh"
module pwc_channel_tb_top;
  logic clk = 0;
  logic rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata, rd, cnt0, period, highTime;
  logic pready, pslverr, pwmOut, rdErr;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  // ====
  // design and pin load
  pwc_channel #(.CW(8)) pwc_channel_inst (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwmOut(pwmOut));
  pwc_pin_load pwc_pin_load_inst (.clk(clk), .pin(pwmOut), .period(period),
    .highTime(highTime));
  initial forever #2 clk = ~clk;
  // ====
  // tasks
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; read data and error taken at the pready edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    rdErr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      report_and_stop;
    end
  end
  // ====
  // sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    apb(0, `PWC_ADDR_COUNTER, 0);
    chk(rd, 0);
    apb(0, 12'h020, 0);
    chk({rd[30:0], rdErr}, 32'h00000001);
    // tick every second clk so one channel tick is two cycles
    apb(1, `PWC_ADDR_PRESCALE, 1);
    apb(1, `PWC_ADDR_PERIOD, 32'hffffff05);
    apb(0, `PWC_ADDR_PERIOD, 0);
    chk(rd, 32'h00000005);
    apb(1, `PWC_ADDR_DUTY, 2);
    apb(1, `PWC_ADDR_CTRL, 1);
    repeat (40) @(posedge clk);
    chk(period, 10);
    chk(highTime, 6);
    apb(1, `PWC_ADDR_PERIOD, 8);
    apb(0, `PWC_ADDR_PERIOD, 0);
    chk(rd, 8);
    repeat (60) @(posedge clk);
    chk(period, 16);
    apb(1, `PWC_ADDR_CTRL, 3);
    repeat (60) @(posedge clk);
    chk(highTime, 4);
    apb(1, `PWC_ADDR_CTRL, 5);
    repeat (100) @(posedge clk);
    chk(period, 32);
    apb(1, `PWC_ADDR_CTRL, 0);
    apb(0, `PWC_ADDR_COUNTER, 0);
    cnt0 = rd;
    repeat (10) @(posedge clk);
    apb(0, `PWC_ADDR_COUNTER, 0);
    chk(rd, cnt0);
    apb(1, `PWC_ADDR_COUNTER, 32'h0000005a);
    apb(0, `PWC_ADDR_COUNTER, 0);
    chk(rd, 0);
    report_and_stop;
  end
endmodule

/* testbench/pwc_pin_load.sv */
`timescale 1ns/10ps
// load on the pin: times the last full period and high phase in clk cycles
module pwc_pin_load (
  // clock and pin
  input wire clk,
  input wire pin,
  // measurements
  output logic [31:0] period,
  output logic [31:0] highTime
);
  logic [31:0] cnt = 0;
  logic [31:0] hcnt = 0;
  logic last = 0;
  initial begin
    period = 0;
    highTime = 0;
  end
  always @(posedge clk) begin
    last <= pin;
    cnt <= (pin && !last) ? 1 : cnt + 1;
    hcnt <= last ? hcnt + 1 : 1;
    if (pin && !last) period <= cnt;
    if (!pin && last) highTime <= hcnt;
  end
endmodule
